// File: timer_channel.v
// One 16-bit timer channel with APB registers, capture and waveform modes
// Contract
// - Enable command enables clock unless disable set
// - Disable command stops clock, wins over enable
// - Software trigger zeroes counter and starts clock
// - Edge invert picks rising or falling count edge
// - Gate select ANDs clock with external line
// - Capture: hold_b load stops clock when set
// - Capture: hold_b load disables clock when set
// - Capture: trigger edge none, rise, fall, both
// - Capture: trigger from line_b or line_a
// - Limit match resets counter when enabled
// - Mode bit selects capture or waveform
// - Capture: hold_a loads on chosen line_a edge
// - Capture: hold_b loads on chosen line_a edge
// - Waveform: limit match stops clock when set
// - Waveform: limit match disables clock when set
// - Waveform: event edge none, rise, fall, both
// - Waveform: event source; line_b becomes input
// - Waveform: event trigger resets counter when enabled
// - Waveform: line_a effects set, clear, toggle
// - Waveform: line_b effects set, clear, toggle
// - Coinciding events: soft, event, limit, hold
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "timer_defs.vh"

module timer_channel #(
  parameter CW = 16                  // Counter width
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        ext_clock_0,
  input  wire        ext_clock_1,
  input  wire        ext_clock_2,
  input  wire        line_a_in,
  output wire        line_a_out,
  output wire        line_a_oe,
  input  wire        line_b_in,
  output wire        line_b_out,
  output wire        line_b_oe
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Edge code: bit 0 picks rising, bit 1 picks falling, both means each
  function edge_hit;
    input [1:0] code;
    input       rise;
    input       fall;
    begin
      edge_hit = (code[0] & rise) | (code[1] & fall);
    end
  endfunction

  // Apply an effect code to an output level
  function apply_eff;
    input       cur;
    input [1:0] code;
    begin
      case (code)
        `EFF_SET:    apply_eff = 1'b1;
        `EFF_CLEAR:  apply_eff = 1'b0;
        `EFF_TOGGLE: apply_eff = ~cur;
        default:     apply_eff = cur;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  wire [4:0] raw_in;                 // ext0, ext1, ext2, line_a, line_b
  reg  [4:0] meta_q;                 // First stage, read only by sync_q
  reg  [4:0] sync_q;                 // Safe level
  reg  [4:0] prev_q;                 // Previous safe level for edges
  wire [4:0] in_rise;
  wire [4:0] in_fall;

  assign raw_in = {line_b_in, line_a_in, ext_clock_2, ext_clock_1, ext_clock_0};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      // Two flops before any logic looks at the pin
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_in[gi];
          sync_q[gi] <= meta_q[gi];
          prev_q[gi] <= sync_q[gi];
        end
      end
      assign in_rise[gi] = sync_q[gi] & ~prev_q[gi];
      assign in_fall[gi] = ~sync_q[gi] & prev_q[gi];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  wire [4:0] div_level;              // Divided pclk levels

  timer_prescaler u_pre (
    .pclk      (pclk),
    .presetn   (presetn),
    .div_level (div_level)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg [31:0]   mode_q;               // Mode register
  reg [CW-1:0] count_q;              // Counter value
  reg [CW-1:0] hold_a_q;             // Hold register A
  reg [CW-1:0] hold_b_q;             // Hold register B
  reg [CW-1:0] limit_q;              // Limit register C
  reg          clk_en_q;             // Counter clock enabled
  reg          stopped_q;            // Clock stopped until next trigger
  reg          gated_q;              // Previous gated clock level
  reg          line_a_q;             // Driven level of line_a
  reg          line_b_q;             // Driven level of line_b
  reg          line_a_oe_q;
  reg          line_b_oe_q;
  reg          pready_q;
  reg          pslverr_q;
  reg [31:0]   prdata_q;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // One wait state: pready rises one edge into the access phase, and the
  // write lands on the edge where the master sees pready high
  wire access  = psel & penable & ~pready_q;
  wire fire    = psel & penable & pready_q;
  wire wr_fire = fire & pwrite;
  wire wr_cmd  = wr_fire & (paddr == `OFF_COMMAND);
  wire wr_mode = wr_fire & (paddr == `OFF_MODE);
  wire mapped  = (paddr == `OFF_COMMAND) | (paddr == `OFF_MODE) |
                 (paddr == `OFF_COUNT) | (paddr == `OFF_HOLD_A) |
                 (paddr == `OFF_HOLD_B) | (paddr == `OFF_LIMIT) |
                 (paddr == `OFF_STATUS);

  wire cmd_en   = wr_cmd & pwdata[`CMD_ENABLE];
  wire cmd_dis  = wr_cmd & pwdata[`CMD_DISABLE];
  wire soft_trg = wr_cmd & pwdata[`CMD_SOFT];

  // ----------------------------------------------------------------------
  // Mode fields
  // ----------------------------------------------------------------------
  wire       wave     = mode_q[`M_WAVE];
  wire [2:0] clk_sel  = mode_q[`M_CLK_SEL];
  wire [1:0] gate_sel = mode_q[`M_GATE];
  wire [1:0] evt_sel  = mode_q[`M_EVT_SEL];

  // ----------------------------------------------------------------------
  // Count clock selection and edge
  // ----------------------------------------------------------------------
  reg sel_level;                     // Selected clock level
  reg gate_level;                    // Gate level, 1 when ungated

  // Choose the counting clock and its gate
  always @* begin
    if (clk_sel < `CS_EXT0) begin
      sel_level = div_level[clk_sel];
    end else begin
      sel_level = sync_q[clk_sel - `CS_EXT0];
    end
    if (gate_sel == `GATE_NONE) begin
      gate_level = 1'b1;
    end else begin
      gate_level = sync_q[gate_sel - 2'h1];
    end
  end

  wire gated  = sel_level & gate_level;
  // Invert picks the falling edge of the gated clock
  wire c_edge = mode_q[`M_EDGE_INV] ? (gated_q & ~gated)
                                    : (gated & ~gated_q);
  wire tick   = c_edge & clk_en_q & ~stopped_q;

  // ----------------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------------
  // Matches are taken on the count edge while the counter holds the value
  wire lim_hit  = tick & (count_q == limit_q);
  wire hold_a_m = wave & tick & (count_q == hold_a_q);
  wire hold_b_m = wave & tick & (count_q == hold_b_q);

  // Capture trigger pin: line_a when select is 1, else line_b
  wire trig_pin = mode_q[`M_TRIG_PIN];
  wire cap_trg  = ~wave & edge_hit(mode_q[`M_TRIG_EDGE],
                                   trig_pin ? in_rise[3] : in_rise[4],
                                   trig_pin ? in_fall[3] : in_fall[4]);
  wire load_a   = ~wave & edge_hit(mode_q[`M_LOAD_A], in_rise[3], in_fall[3]);
  wire load_b   = ~wave & edge_hit(mode_q[`M_LOAD_B], in_rise[3], in_fall[3]);

  // Waveform event source: line_b for code 0, else an external clock line
  wire evt_rise = (evt_sel == `EVT_LINE_B) ? in_rise[4] : in_rise[evt_sel - 2'h1];
  wire evt_fall = (evt_sel == `EVT_LINE_B) ? in_fall[4] : in_fall[evt_sel - 2'h1];
  wire ext_evt  = wave & edge_hit(mode_q[`M_TRIG_EDGE], evt_rise, evt_fall);

  wire trigger  = soft_trg
                | cap_trg
                | (ext_evt & mode_q[`M_EVT_TRIG])
                | (lim_hit & mode_q[`M_LIMIT_TRIG]);

  // Stop and disable sources depend on the mode
  wire hw_stop  = (~wave & load_b & mode_q[`M_STOP])
                | (wave & lim_hit & mode_q[`M_STOP]);
  wire hw_dis   = (~wave & load_b & mode_q[`M_DISABLE])
                | (wave & lim_hit & mode_q[`M_DISABLE]);

  // ----------------------------------------------------------------------
  // Counter and clock control
  // ----------------------------------------------------------------------
  // Disable from software or hardware wins over enable; a stop event wins
  // over a trigger in the same cycle so a stop is never lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q   <= {CW{1'b0}};
      clk_en_q  <= 1'b0;
      stopped_q <= 1'b1;
      gated_q   <= 1'b0;
    end else begin
      gated_q <= gated;
      if (trigger) begin
        count_q <= {CW{1'b0}};
      end else if (tick & ~hw_stop & ~hw_dis) begin     // Count rests at the limit match or hold_b load
        count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
      end
      if (cmd_dis | hw_dis) begin
        clk_en_q <= 1'b0;
      end else if (cmd_en) begin
        clk_en_q <= 1'b1;
      end
      if (hw_stop) begin
        stopped_q <= 1'b1;
      end else if (trigger) begin
        stopped_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mode, hold and limit registers
  // ----------------------------------------------------------------------
  // Hold registers load from the counter in capture mode and are
  // software writable only in waveform mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q   <= `MODE_RESET;
      hold_a_q <= {CW{1'b0}};
      hold_b_q <= {CW{1'b0}};
      limit_q  <= {CW{1'b0}};
    end else begin
      if (wr_mode) begin
        mode_q <= pwdata & `MODE_MASK;
      end
      if (load_a) begin
        hold_a_q <= count_q;
      end else if (wr_fire & wave & (paddr == `OFF_HOLD_A)) begin
        hold_a_q <= pwdata[CW-1:0];
      end
      if (load_b) begin
        hold_b_q <= count_q;
      end else if (wr_fire & wave & (paddr == `OFF_HOLD_B)) begin
        hold_b_q <= pwdata[CW-1:0];
      end
      if (wr_fire & (paddr == `OFF_LIMIT)) begin
        limit_q <= pwdata[CW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output controller
  // ----------------------------------------------------------------------
  // Only the highest-priority event with a non-zero effect acts
  reg [1:0] eff_a;
  reg [1:0] eff_b;
  wire      b_out_en = wave & (evt_sel != `EVT_LINE_B);

  // Pick effects: soft, then event, then limit, then hold match
  always @* begin
    eff_a = `EFF_NONE;
    eff_b = `EFF_NONE;
    if (soft_trg && mode_q[`M_A_SOFT] != `EFF_NONE) begin
      eff_a = mode_q[`M_A_SOFT];
    end else if (ext_evt && mode_q[`M_A_EVENT] != `EFF_NONE) begin
      eff_a = mode_q[`M_A_EVENT];
    end else if (lim_hit && mode_q[`M_A_LIMIT] != `EFF_NONE) begin
      eff_a = mode_q[`M_A_LIMIT];
    end else if (hold_a_m) begin
      eff_a = mode_q[`M_A_HOLD];
    end
    if (soft_trg && mode_q[`M_B_SOFT] != `EFF_NONE) begin
      eff_b = mode_q[`M_B_SOFT];
    end else if (ext_evt && mode_q[`M_B_EVENT] != `EFF_NONE) begin
      eff_b = mode_q[`M_B_EVENT];
    end else if (lim_hit && mode_q[`M_B_LIMIT] != `EFF_NONE) begin
      eff_b = mode_q[`M_B_LIMIT];
    end else if (hold_b_m) begin
      eff_b = mode_q[`M_B_HOLD];
    end
  end

  // Levels change only in waveform mode; line_b only while it drives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_a_q    <= 1'b0;
      line_b_q    <= 1'b0;
      line_a_oe_q <= 1'b0;
      line_b_oe_q <= 1'b0;
    end else begin
      line_a_oe_q <= wave;
      line_b_oe_q <= b_out_en;
      if (wave) begin
        line_a_q <= apply_eff(line_a_q, eff_a);
      end
      if (b_out_en) begin
        line_b_q <= apply_eff(line_b_q, eff_b);
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------------
  reg [31:0] rd_mux;                 // Read data of addressed register
  wire mirror_a = wave ? line_a_q : sync_q[3];
  wire mirror_b = b_out_en ? line_b_q : sync_q[4];

  // Read mux; the command register reads as zero
  always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
      `OFF_MODE:   rd_mux = mode_q;
      `OFF_COUNT:  rd_mux[CW-1:0] = count_q;
      `OFF_HOLD_A: rd_mux[CW-1:0] = hold_a_q;
      `OFF_HOLD_B: rd_mux[CW-1:0] = hold_b_q;
      `OFF_LIMIT:  rd_mux[CW-1:0] = limit_q;
      `OFF_STATUS: begin
        rd_mux[`ST_CLK_EN] = clk_en_q;
        rd_mux[`ST_LINE_A] = mirror_a;
        rd_mux[`ST_LINE_B] = mirror_b;
      end
      default:     rd_mux = 32'h00000000;
    endcase
  end

  // Answer registered so every bus output leaves a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q <= access;
      if (access) begin
        pslverr_q <= ~mapped;
        prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign prdata     = prdata_q;
  assign line_a_out = line_a_q;
  assign line_a_oe  = line_a_oe_q;
  assign line_b_out = line_b_q;
  assign line_b_oe  = line_b_oe_q;

endmodule // timer_channel

// File: timer_defs.vh
// Register offsets, field positions, codes and reset values of the timer channel
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFF_COMMAND     8'h00
`define OFF_MODE        8'h04
`define OFF_COUNT       8'h10
`define OFF_HOLD_A      8'h14
`define OFF_HOLD_B      8'h18
`define OFF_LIMIT       8'h1C
`define OFF_STATUS      8'h20

// ----------------------------------------------------------------------
// Command register bits
// ----------------------------------------------------------------------
`define CMD_ENABLE      0
`define CMD_DISABLE     1
`define CMD_SOFT        2

// ----------------------------------------------------------------------
// Mode register fields (shared and per-mode)
// ----------------------------------------------------------------------
`define M_CLK_SEL       2:0
`define M_EDGE_INV      3
`define M_GATE          5:4
`define M_STOP          6
`define M_DISABLE       7
`define M_TRIG_EDGE     9:8
`define M_TRIG_PIN      10
`define M_EVT_SEL       11:10
`define M_EVT_TRIG      12
`define M_LIMIT_TRIG    14
`define M_WAVE          15
`define M_LOAD_A        17:16
`define M_LOAD_B        19:18
`define M_A_HOLD        17:16
`define M_A_LIMIT       19:18
`define M_A_EVENT       21:20
`define M_A_SOFT        23:22
`define M_B_HOLD        25:24
`define M_B_LIMIT       27:26
`define M_B_EVENT       29:28
`define M_B_SOFT        31:30
`define MODE_RESET      32'h00000000
`define MODE_MASK       32'hFFFFDFFF

// ----------------------------------------------------------------------
// Status register bits
// ----------------------------------------------------------------------
`define ST_CLK_EN       16
`define ST_LINE_A       17
`define ST_LINE_B       18

// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define EFF_NONE        2'h0
`define EFF_SET         2'h1
`define EFF_CLEAR       2'h2
`define EFF_TOGGLE      2'h3
`define CS_EXT0         3'h5
`define GATE_NONE       2'h0
`define EVT_LINE_B      2'h0

// ----------------------------------------------------------------------
// Prescaler taps: bit k of a free counter has a period of 2^(k+1) clocks
// ----------------------------------------------------------------------
`define PRE_WIDTH       10
`define TAP_DIV2        0
`define TAP_DIV8        2
`define TAP_DIV32       4
`define TAP_DIV128      6
`define TAP_DIV1024     9

`endif

// File: timer_prescaler.v
// Free-running prescaler giving the five divided clock levels
`timescale 1ns/1ps
`include "timer_defs.vh"

module timer_prescaler (
  input  wire       pclk,
  input  wire       presetn,
  output wire [4:0] div_level
);

  reg [`PRE_WIDTH-1:0] pre_q;   // Free counter, never stops

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Free running so all channels sharing it see a stable phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= {`PRE_WIDTH{1'b0}};
    end else begin
      pre_q <= pre_q + {{(`PRE_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Levels for /2, /8, /32, /128, /1024 in select order
  assign div_level = {pre_q[`TAP_DIV1024], pre_q[`TAP_DIV128], pre_q[`TAP_DIV32],
                      pre_q[`TAP_DIV8], pre_q[`TAP_DIV2]};

endmodule // timer_prescaler

// File: timer_channel_props.sv
// Bus and line-enable checks on the timer channel ports
`timescale 1ns/1ps
`include "timer_defs.vh"
module timer_channel_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        line_a_oe,
  input wire        line_b_oe
);
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc  = psel && penable && pready;          // Completing transfer
  wire mw   = acc && pwrite && paddr == `OFF_MODE; // Mode write lands
  wire wv   = pwdata[15];                        // Waveform bit written
  wire ev   = pwdata[11:10] != 2'h0;             // Event source not line_b
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  idle_quiet_a: assert property (!psel |-> !pready && !pslverr) else $error("answer without select");
  err_unmapped_a: assert property (acc && paddr == 8'h08 |-> pslverr) else $error("hole not refused");
  err_mapped_a: assert property (acc && paddr == `OFF_MODE |-> !pslverr) else $error("mode refused");
  cmd_reads_zero_a: assert property (acc && !pwrite && paddr == `OFF_COMMAND |-> prdata == 32'h0)
    else $error("command read not zero");
  mode_readback_a: assert property (mw ##4 (acc && !pwrite && paddr == `OFF_MODE)
    |-> prdata == ($past(pwdata, 4) & `MODE_MASK)) else $error("mode readback wrong");
  oe_a_wave_a: assert property (mw |-> ##2 line_a_oe == $past(wv, 2))
    else $error("line_a enable wrong");
  oe_b_event_a: assert property (mw |-> ##2 line_b_oe == ($past(wv, 2) && $past(ev, 2)))
    else $error("line_b enable wrong");
  cover property (acc && pslverr);
  cover property (line_a_oe && line_b_oe);
  cover property (acc && pwrite && paddr == `OFF_COMMAND);
endmodule // timer_channel_props

bind timer_channel timer_channel_props props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .line_a_oe(line_a_oe), .line_b_oe(line_b_oe));

// File: ext_partner.sv
// Far-side model: external clock lines and the two I/O pins
`timescale 1ns/1ps
module ext_partner (
  input  wire pclk,
  input  wire line_a_out,
  input  wire line_a_oe,
  input  wire line_b_out,
  input  wire line_b_oe,
  output reg  ext_clock_0 = 1'b0,
  output reg  ext_clock_1 = 1'b0,
  output reg  ext_clock_2 = 1'b0,
  output wire line_a_in,
  output wire line_b_in
);
  // ----------------------------------------------------------------------
  // Pins: channel wins while it drives, else our own level
  // ----------------------------------------------------------------------
  reg a_drv = 1'b0; // Level we put on line_a
  reg b_drv = 1'b0; // Level we put on line_b
  assign line_a_in = line_a_oe ? line_a_out : a_drv;
  assign line_b_in = line_b_oe ? line_b_out : b_drv;
  // Clock frame on ext_clock_0; it rests low between frames
  task automatic pulse(input int n, input int half);
    repeat (n) begin
      @(posedge pclk);
      ext_clock_0 <= 1'b1;
      repeat (half) @(posedge pclk);
      ext_clock_0 <= 1'b0;
      repeat (half) @(posedge pclk);
    end
  endtask
  // New pin levels after the next edge
  task automatic pins(input logic a, input logic b);
    @(posedge pclk);
    a_drv <= a;
    b_drv <= b;
  endtask
endmodule // ext_partner

// File: tb_timer_channel.sv
// Self-checking bench for the timer channel
`timescale 1ns/1ps
`include "timer_defs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_timer_channel;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0; // Reset, active low
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, r;
  wire  [31:0] prdata;
  wire         pready, pslverr, x0, x1, x2, ai, ao, ae, bi, bo, be;
  typedef struct {logic [31:0] e; logic [31:0] m; bit nz; logic err;} note_t;
  note_t       q[$];           // Expected answers, oldest first
  note_t       nt;
  int          checks = 0, miscompares = 0, cyc = 0, n, i;
  always #20 pclk = ~pclk;
  timer_channel timer_channel_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clock_0(x0), .ext_clock_1(x1),
    .ext_clock_2(x2), .line_a_in(ai), .line_a_out(ao), .line_a_oe(ae),
    .line_b_in(bi), .line_b_out(bo), .line_b_oe(be));
  ext_partner ext_partner_i (.pclk(pclk), .line_a_out(ao), .line_a_oe(ae), .line_b_out(bo),
    .line_b_oe(be), .ext_clock_0(x0), .ext_clock_1(x1), .ext_clock_2(x2),
    .line_a_in(ai), .line_b_in(bi));
  // ----------------------------------------------------------------------
  // Bus master: note the answer, then hold the request until ready
  // ----------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic [31:0] m, input bit nz, input logic err);
    q.push_back('{e, m, nz, err});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // Idle cycle keeps each signal to one change a step
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0, 1'b0);
  endtask
  // Watcher: compare each completed answer with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      `CHK(pslverr, nt.err)
      if (nt.nz) `CHK(|(prdata & nt.m), 1'b1)
      else `CHK(prdata & nt.m, nt.e)
    end
  end
  // Hang guard, far above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      results();
    end
  end
  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(19980));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFF_MODE, `MODE_RESET, 32'hFFFFFFFF);
    r = $urandom;
    wr(`OFF_MODE, r);
    rd(`OFF_MODE, r & `MODE_MASK, 32'hFFFFFFFF);
    apb(1'b0, 8'h08, 32'h0, 32'h0, 32'h0, 1'b0, 1'b1);
    rd(`OFF_COMMAND, 32'h0, 32'hFFFFFFFF);
    wr(`OFF_COMMAND, 32'h1);
    rd(`OFF_STATUS, 32'h10000, 32'h10000);
    wr(`OFF_COMMAND, 32'h3);
    rd(`OFF_STATUS, 32'h0, 32'h10000);
    // External clock counted on rising, then falling; then gated by a low line
    for (i = 0; i < 3; i++) begin
      n = 1 + $urandom % 6;
      wr(`OFF_MODE, {26'h0, (i == 2) ? 2'h2 : 2'h0, i == 1, `CS_EXT0});
      wr(`OFF_COMMAND, 32'h5);
      ext_partner_i.pulse(n, 2 + $urandom % 3);
      repeat (6) @(posedge pclk);
      rd(`OFF_COUNT, (i == 2) ? 32'h0 : n, 32'hFFFF);
    end
    // Soft-trigger effects on both lines: clear, set, toggle, toggle
    for (i = 0; i < 4; i++) begin
      n = (i == 0) ? 2 : (i == 1) ? 1 : 3;
      wr(`OFF_MODE, 32'h8400 | n << 22 | n << 30);
      wr(`OFF_COMMAND, 32'h4);
      rd(`OFF_STATUS, (i % 2) ? 32'h60000 : 32'h0, 32'h60000);
    end
    // Limit match stops, disables and clears line_a
    wr(`OFF_LIMIT, 32'h5);
    wr(`OFF_MODE, 32'h000884C0);
    wr(`OFF_COMMAND, 32'h5);
    repeat (60) @(posedge pclk);
    rd(`OFF_COUNT, 32'h5, 32'hFFFF);
    rd(`OFF_STATUS, 32'h0, 32'h30000);
    // Capture: falling line_b ignored, rising line_b starts, line_a rise loads
    wr(`OFF_MODE, 32'h00010100);
    wr(`OFF_COMMAND, 32'h1);
    rd(`OFF_COUNT, 32'h5, 32'hFFFF);
    rd(`OFF_HOLD_A, 32'h0, 32'hFFFF);
    ext_partner_i.pins(1'b0, 1'b1);
    repeat (20) @(posedge pclk);
    ext_partner_i.pins(1'b1, 1'b1);
    repeat (6) @(posedge pclk);
    apb(1'b0, `OFF_HOLD_A, 32'h0, 32'h0, 32'hFFFF, 1'b1, 1'b0);
    // Capture: line_a fall loads hold_b, then stops (pass 0) or disables (pass 1)
    for (i = 0; i < 2; i++) begin
      ext_partner_i.pins(1'b1, 1'b1);
      wr(`OFF_MODE, 32'h00080005 | 32'h40 << i);
      wr(`OFF_COMMAND, 32'h5);
      ext_partner_i.pulse(3, 2);
      ext_partner_i.pins(1'b0, 1'b1);
      repeat (6) @(posedge pclk);
      ext_partner_i.pulse(2, 2);
      rd(`OFF_HOLD_B, 32'h3, 32'hFFFF);
      rd(`OFF_COUNT, 32'h3, 32'hFFFF);
      rd(`OFF_STATUS, i ? 32'h0 : 32'h10000, 32'h10000);
    end
    // Waveform: line_b rise triggers and sets line_a; limit match re-triggers, clears
    wr(`OFF_MODE, 32'h0018D105);
    wr(`OFF_COMMAND, 32'h1);
    ext_partner_i.pulse(1, 2);
    ext_partner_i.pins(1'b0, 1'b0);
    repeat (3) @(posedge pclk);
    ext_partner_i.pins(1'b0, 1'b1);
    repeat (6) @(posedge pclk);
    rd(`OFF_COUNT, 32'h0, 32'hFFFF);
    rd(`OFF_STATUS, 32'h20000, 32'h20000);
    ext_partner_i.pulse(6, 2);
    rd(`OFF_COUNT, 32'h0, 32'hFFFF);
    rd(`OFF_STATUS, 32'h0, 32'h20000);
    results();
  end
endmodule // tb_timer_channel
